// ==== hw/ssd_fifo.sv ====
// Parameterised valid/ready FIFO.
module ssd_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// Clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;
	assign out_data = mem[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // ssd_fifo

// ==== hw/ssd_pkg.sv ====
// Package of constants and carrier types for the serial shift sink driver.
package ssd_pkg;
	localparam int SSD_CHANNELS = 12;
	localparam int SSD_FIFO_DEPTH = 16;
	localparam int SSD_SYNC_STAGES = 2;
	localparam logic [SSD_CHANNELS-1:0] SSD_ZERO = 12'h000;
	localparam logic [3:0] SSD_CNT_ZERO = 4'h0;
	localparam logic [3:0] SSD_CNT_ONE = 4'h1;

	typedef struct packed {
		logic shift_clock;
		logic storage_load_clock;
		logic register_clear_n;
		logic shift_data_in;
		logic output_enable_n;
		logic over_temp;
	} ssd_pins_s;

	typedef enum logic [1:0] {
		SSD_RUN = 2'b00,
		SSD_HOT = 2'b01
	} ssd_therm_e;
endpackage : ssd_pkg

// ==== hw/ssd_sync.sv ====
// Two-stage synchroniser for a bundle of pin levels.
module ssd_sync #(
	parameter int WIDTH = 6
) (
	// Clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else if (ce) begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule // ssd_sync

// ==== hw/ssd_top.sv ====
// Serial shift register with storage stage driving twelve open-drain sinks.
// Summary of operation
// - A twelve-stage serial-in parallel-out shift register feeds a twelve-bit storage register.
// - The shift register advances on each shift clock rise and storage loads on each storage clock rise.
// - Storage data reaches the output buffers only while the clear input is high.
// - A low clear input zeroes the shift, storage, cascade and buffer stages and the overrun flag; the snapshot FIFO keeps its entries.
// - The cascade output updates on the falling shift clock edge.
// - A bit at the serial input reaches the cascade output eleven and a half shift clock periods after its sampling rise.
// - The cascade output feeds the next device and changes away from its sampling rising edge.
// - While output enable is high all buffers are low and every drain is off.
// - While output enable is low the buffers follow the storage register.
// - A buffer bit of one turns its sink on and zero turns it off.
// - With enable low and clear high the drains change at the storage clock rise.
// - An over-temperature indication forces all outputs open until it is released.
module ssd_top
	import ssd_pkg::*;
#(
	parameter int CHANNELS = ssd_pkg::SSD_CHANNELS,
	parameter int FIFO_DEPTH = ssd_pkg::SSD_FIFO_DEPTH
) (
	// Clock, reset and enable
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	// Host pins
	input wire logic SHIFT_CLOCK,
	input wire logic STORAGE_LOAD_CLOCK,
	input wire logic REGISTER_CLEAR_N,
	input wire logic SHIFT_DATA_IN,
	input wire logic OUTPUT_ENABLE_N,
	// Thermal indication, high while hot; low again only below release threshold
	input wire logic OVER_TEMP,
	// Cascade output
	output logic CASCADE_DATA_OUT,
	// Open-drain sink outputs: pin level out is always low, enable means sinking
	output logic [CHANNELS-1:0] DRAIN_OUT,
	output logic [CHANNELS-1:0] DRAIN_OE,
	// Storage snapshot stream
	output logic SNAP_VALID,
	input wire logic SNAP_READY,
	output logic [CHANNELS-1:0] SNAP_DATA,
	output logic SNAP_OVERRUN
);
	import ssd_pkg::*;

	ssd_pins_s pins_raw;
	ssd_pins_s pins;
	logic shift_clock_prev_q;
	logic rck_prev_q;
	logic shift_clock_rise;
	logic shift_clock_fall;
	logic rck_rise;
	logic clear;
	logic [CHANNELS-1:0] shift_q;
	logic [CHANNELS-1:0] store_q;
	logic [CHANNELS-1:0] buf_q;
	logic cascade_q;
	ssd_therm_e therm_q;
	logic fifo_in_ready;
	logic overrun_q;

	assign pins_raw = '{shift_clock: SHIFT_CLOCK, storage_load_clock: STORAGE_LOAD_CLOCK,
		register_clear_n: REGISTER_CLEAR_N, shift_data_in: SHIFT_DATA_IN,
		output_enable_n: OUTPUT_ENABLE_N, over_temp: OVER_TEMP};

	// Every pin crosses into MCLK before any logic reads it.
	ssd_sync #(
		.WIDTH($bits(ssd_pins_s))
	) u_sync (
		.clk(MCLK),
		.rst(SYS_RST),
		.ce(CLK_EN),
		.d(pins_raw),
		.q(pins)
	);

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			shift_clock_prev_q <= 1'b0;
			rck_prev_q <= 1'b0;
		end else if (CLK_EN) begin
			shift_clock_prev_q <= pins.shift_clock;
			rck_prev_q <= pins.storage_load_clock;
		end
	end

	assign shift_clock_rise = pins.shift_clock && !shift_clock_prev_q;
	assign shift_clock_fall = !pins.shift_clock && shift_clock_prev_q;
	assign rck_rise = pins.storage_load_clock && !rck_prev_q;
	// Clear is level sensitive and wins over any edge seen in the same cycle.
	assign clear = !pins.register_clear_n;

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			shift_q <= SSD_ZERO;
		end else if (CLK_EN && clear) begin
			shift_q <= SSD_ZERO;
		end else if (CLK_EN && shift_clock_rise) begin
			shift_q <= {shift_q[CHANNELS-2:0], pins.shift_data_in};
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			cascade_q <= 1'b0;
		end else if (CLK_EN && clear) begin
			cascade_q <= 1'b0;
		end else if (CLK_EN && shift_clock_fall) begin
			cascade_q <= shift_q[CHANNELS-1];
		end
	end

	assign CASCADE_DATA_OUT = cascade_q;

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			store_q <= SSD_ZERO;
		end else if (CLK_EN && clear) begin
			store_q <= SSD_ZERO;
		end else if (CLK_EN && rck_rise) begin
			store_q <= shift_q;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			therm_q <= SSD_RUN;
		end else if (CLK_EN) begin
			unique case (therm_q)
				SSD_RUN: begin
					if (pins.over_temp) begin
						therm_q <= SSD_HOT;
					end
				end
				SSD_HOT: begin
					if (!pins.over_temp) begin
						therm_q <= SSD_RUN;
					end
				end
				default: begin
					therm_q <= SSD_HOT;
				end
			endcase
		end
	end

	// Output buffers; gating here rather than in the register keeps PWM dimming free of reloads.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			buf_q <= SSD_ZERO;
		end else if (CLK_EN) begin
			if (clear || pins.output_enable_n || therm_q != SSD_RUN) begin
				buf_q <= SSD_ZERO;
			end else begin
				buf_q <= store_q;
			end
		end
	end

	assign DRAIN_OE = buf_q;
	assign DRAIN_OUT = SSD_ZERO;

	// Each storage load is offered as a snapshot; a full FIFO drops it and flags overrun.
	ssd_fifo #(
		.WIDTH(CHANNELS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(MCLK),
		.rst(SYS_RST),
		.ce(CLK_EN),
		.in_valid(rck_rise && !clear),
		.in_ready(fifo_in_ready),
		.in_data(shift_q),
		.out_valid(SNAP_VALID),
		.out_ready(SNAP_READY),
		.out_data(SNAP_DATA)
	);

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			overrun_q <= 1'b0;
		end else if (CLK_EN && rck_rise && !clear && !fifo_in_ready) begin
			overrun_q <= 1'b1;
		end else if (CLK_EN && clear) begin
			overrun_q <= 1'b0;
		end
	end

	assign SNAP_OVERRUN = overrun_q;
endmodule // ssd_top

// ==== tb/ssd_chk.sv ====
// Port checker for the serial shift sink driver.
module ssd_chk #(
	parameter int CHANNELS = 12
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	// Host pins
	input wire logic SHIFT_CLOCK,
	input wire logic STORAGE_LOAD_CLOCK,
	input wire logic REGISTER_CLEAR_N,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic OVER_TEMP,
	// Outputs
	input wire logic CASCADE_DATA_OUT,
	input wire logic [CHANNELS-1:0] DRAIN_OUT,
	input wire logic [CHANNELS-1:0] DRAIN_OE,
	input wire logic SNAP_VALID,
	input wire logic SNAP_OVERRUN
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge MCLK); endclocking
	// A frozen block holds its outputs, so no cycle-counted check may run across a freeze.
	default disable iff (SYS_RST || !CLK_EN);
	drain_level_a: assert property (DRAIN_OUT == '0)
		else $error("drain level not low");
	oe_off_a: assert property (OUTPUT_ENABLE_N [*7] |-> DRAIN_OE == '0)
		else $error("drains on with enable high");
	clear_zero_a: assert property (!REGISTER_CLEAR_N [*7] |-> DRAIN_OE == '0 && !CASCADE_DATA_OUT)
		else $error("clear left state");
	hot_off_a: assert property (OVER_TEMP [*7] |-> DRAIN_OE == '0)
		else $error("drains on while hot");
	cascade_fall_a: assert property ($changed(CASCADE_DATA_OUT) |->
		!SHIFT_CLOCK || !REGISTER_CLEAR_N || !$past(REGISTER_CLEAR_N, 6)) else $error("cascade moved off fall");
	load_snap_a: assert property ($rose(STORAGE_LOAD_CLOCK) && REGISTER_CLEAR_N |-> ##[2:6] SNAP_VALID)
		else $error("load not captured");
	overrun_hold_a: assert property ($fell(SNAP_OVERRUN) |-> !REGISTER_CLEAR_N)
		else $error("overrun dropped without clear");
	drains_hold_a: assert property (($stable(OUTPUT_ENABLE_N) && $stable(STORAGE_LOAD_CLOCK) &&
		$stable(REGISTER_CLEAR_N) && $stable(OVER_TEMP)) [*7] |-> $stable(DRAIN_OE)) else $error("drains moved");
endmodule // ssd_chk

// ==== tb/ssd_host.sv ====
// Host model that drives the pins and records the cascade output.
module ssd_host (
	// Clock and cascade return
	input wire logic clk,
	input wire logic sdo,
	// Pins and recorded cascade bits
	output ssd_pkg::ssd_pins_s pins,
	output logic [11:0] seen
);
	timeunit 1ns;
	timeprecision 100ps;
	import ssd_pkg::*;
	// Start with clear low and enable high.
	initial pins = 6'h02;
	initial seen = 12'h000;
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic load();
		pins.storage_load_clock = 1'b1;
		wait_n(8);
		pins.storage_load_clock = 1'b0;
		wait_n(8);
	endtask
	task automatic put_word(input logic [11:0] w);
		for (int i = 11; i >= 0; i--) begin
			// Data changes only while the clock is low; stale data is inverted.
			pins.shift_data_in = w[i];
			wait_n(8);
			pins.shift_clock = 1'b1;
			wait_n(8);
			pins.shift_clock = 1'b0;
			pins.shift_data_in = ~w[i];
			wait_n(6);
			seen = {seen[10:0], sdo};
			wait_n(2);
		end
	endtask
endmodule // ssd_host

// ==== tb/ssd_top_tb.sv ====
// Self-checking testbench for the serial shift sink driver.
module ssd_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ssd_pkg::*;
	logic MCLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic SNAP_READY = 1'b0;
	logic CLK_EN = 1'b1;
	logic CASCADE_DATA_OUT, SNAP_VALID, SNAP_OVERRUN;
	logic [11:0] DRAIN_OUT, DRAIN_OE, SNAP_DATA, seen;
	ssd_pins_s p;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	always #2.5 MCLK = ~MCLK;
	ssd_host host (.clk(MCLK), .sdo(CASCADE_DATA_OUT), .pins(p), .seen(seen));
	ssd_top dut (.MCLK, .SYS_RST, .CLK_EN, .SHIFT_CLOCK(p.shift_clock),
		.STORAGE_LOAD_CLOCK(p.storage_load_clock), .REGISTER_CLEAR_N(p.register_clear_n),
		.SHIFT_DATA_IN(p.shift_data_in), .OUTPUT_ENABLE_N(p.output_enable_n), .OVER_TEMP(p.over_temp),
		.CASCADE_DATA_OUT, .DRAIN_OUT, .DRAIN_OE, .SNAP_VALID, .SNAP_READY, .SNAP_DATA, .SNAP_OVERRUN);
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (err_total == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic pin_wait(input int sel, input logic v, input logic [11:0] exp);
		if (sel == 0) host.pins.output_enable_n = v;
		else if (sel == 1) host.pins.over_temp = v;
		else host.pins.register_clear_n = v;
		host.wait_n(8);
		check(DRAIN_OE, exp);
	endtask
	task automatic t_fifo;
		int n;
		n = 0;
		repeat (16) host.load();
		check(12'(SNAP_OVERRUN), 12'h001);
		check(SNAP_DATA, 12'hA5C);
		while (SNAP_VALID === 1'b1 && n < 20) begin
			SNAP_READY = 1'b1;
			@(negedge MCLK);
			n++;
		end
		SNAP_READY = 1'b0;
		check(12'(n), 12'h010);
	endtask
	task automatic t_shift;
		host.pins.register_clear_n = 1'b1;
		host.put_word(12'hA5C);
		host.pins.output_enable_n = 1'b0;
		host.load();
		check(DRAIN_OE, 12'hA5C);
		host.put_word(12'hBC9);
		check(seen, 12'h4B9);
		check(DRAIN_OE, 12'hA5C);
	endtask
	task automatic t_gate;
		pin_wait(0, 1'b1, 12'h000);
		pin_wait(0, 1'b0, 12'hA5C);
		// A low clock enable must freeze the drains although the enable pin moved.
		CLK_EN = 1'b0;
		pin_wait(0, 1'b1, 12'hA5C);
		CLK_EN = 1'b1;
		host.wait_n(8);
		check(DRAIN_OE, 12'h000);
		pin_wait(0, 1'b0, 12'hA5C);
		pin_wait(1, 1'b1, 12'h000);
		pin_wait(1, 1'b0, 12'hA5C);
	endtask
	task automatic t_clear;
		pin_wait(2, 1'b0, 12'h000);
		check(12'({CASCADE_DATA_OUT, SNAP_OVERRUN}), 12'h000);
		pin_wait(2, 1'b1, 12'h000);
		host.load();
		check(DRAIN_OE, 12'h000);
	endtask
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		repeat (6) @(negedge MCLK);
		SYS_RST = 1'b0;
		host.wait_n(4);
		t_shift();
		t_gate();
		t_fifo();
		t_clear();
		end_sim();
	end
endmodule // ssd_top_tb
bind ssd_top ssd_chk #(.CHANNELS(CHANNELS)) chk (.MCLK, .SYS_RST, .CLK_EN, .SHIFT_CLOCK, .STORAGE_LOAD_CLOCK,
	.REGISTER_CLEAR_N, .OUTPUT_ENABLE_N, .OVER_TEMP, .CASCADE_DATA_OUT, .DRAIN_OUT, .DRAIN_OE, .SNAP_VALID,
	.SNAP_OVERRUN);
